/* logic/gcr_top.sv */
// global control register bank behind an axi4-lite slave
// ============================================================================
module gcr_top
  import gcr_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  irq_active,
  input  wire logic                  pm_ports_done,
  input  wire logic                  one_sec_tick,
  input  wire logic [7:0]            gp_pin_in,
  input  wire logic [7:0]            port_status,
  input  wire logic                  ref8k_internal,
  output logic                       irq_pin_out,
  output logic                       irq_pin_oe,
  output logic [7:0]                 gp_pin_out,
  output logic [7:0]                 gp_pin_oe,
  output logic                       broadcast_write_mode,
  output logic                       error_insert_pulse,
  output logic                       pm_update_pulse,
  output logic                       latched_clear_on_read,
  output logic                       datapath_reset,
  output logic                       full_reset,
  output logic [2:0]                 ref8k_source_sel,
  output logic                       ref8k_source_ext,
  output logic                       ref8k_in,
  output logic [3:0]                 rate_adapter_pin_mode
);
  import gcr_pkg::*;

  // ==========================================================================
  // input synchronisers: stage one feeds only stage two
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic [2:0] misc_s1_reg;
  logic [2:0] misc_s2_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg  <= 8'h00;
      pin_s2_reg  <= 8'h00;
      misc_s1_reg <= 3'h0;
      misc_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg  <= gp_pin_in;
      pin_s2_reg  <= pin_s1_reg;
      misc_s1_reg <= {irq_active, pm_ports_done, one_sec_tick};
      misc_s2_reg <= misc_s1_reg;
    end
  end

  logic irq_act;
  logic ports_done;
  logic tick;
  assign irq_act    = misc_s2_reg[2];
  assign ports_done = misc_s2_reg[1];
  assign tick       = misc_s2_reg[0];

  // ==========================================================================
  // registers
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic [15:0] pin_sel_reg;
  logic        pm_done_reg;

  // ==========================================================================
  // axi write channel: address and data taken in either order
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic [4:0]  wr_idx;
  logic [15:0] wr_merged;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) res[7:0] = new_v[7:0];
    if (strb[1]) res[15:8] = new_v[15:8];
    return res;
  endfunction

  assign do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx    = aw_addr_reg[6:2];
  assign wr_merged = merge16(ctrl_one_reg, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= GCR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg[7] || aw_addr_reg[1:0] != 2'h0) begin
          s_axi_bresp <= GCR_RESP_SLVERR;
        end else if (wr_idx == GCR_IDX_CTRL_ONE || wr_idx == GCR_IDX_CTRL_TWO
                     || wr_idx == GCR_IDX_PIN_SEL
                     || wr_idx == GCR_IDX_IDENTITY
                     || wr_idx == GCR_IDX_STATUS) begin
          s_axi_bresp <= GCR_RESP_OKAY;
        end else begin
          s_axi_bresp <= GCR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ok;
  assign wr_ok = do_write && !aw_addr_reg[7] && aw_addr_reg[1:0] == 2'h0;

  // control one: reset loads GCR_C1_RESET into every bit, full reset bit included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_reg <= GCR_C1_RESET;
    end else if (wr_ok && wr_idx == GCR_IDX_CTRL_ONE) begin
      ctrl_one_reg <= wr_merged & GCR_C1_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_two_reg <= GCR_C2_RESET;
    end else if (wr_ok && wr_idx == GCR_IDX_CTRL_TWO) begin
      ctrl_two_reg <= merge16(ctrl_two_reg, w_data_reg, w_strb_reg)
                      & GCR_C2_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sel_reg <= GCR_PS_RESET;
    end else if (wr_ok && wr_idx == GCR_IDX_PIN_SEL) begin
      pin_sel_reg <= merge16(pin_sel_reg, w_data_reg, w_strb_reg);
    end
  end

  // ==========================================================================
  // performance update and error insertion triggers
  logic [1:0] pm_mode;
  logic       err_trig;
  logic       err_trig_d_reg;
  logic       pm_trig;
  logic       pm_trig_d_reg;

  assign pm_mode  = ctrl_one_reg[GCR_C1_PM_HI:GCR_C1_PM_LO];
  assign err_trig = ctrl_one_reg[GCR_C1_ERR_SRC] ? pin_s2_reg[5]
                  : ctrl_one_reg[GCR_C1_ERR_INS];

  always_comb begin
    if (pm_mode == GCR_PM_REG) begin
      pm_trig = ctrl_one_reg[GCR_C1_PM_REQ];
    end else if (pm_mode == GCR_PM_PIN) begin
      pm_trig = pin_s2_reg[7];
    end else begin
      pm_trig = tick;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_trig_d_reg     <= 1'b0;
      pm_trig_d_reg      <= 1'b0;
      error_insert_pulse <= 1'b0;
      pm_update_pulse    <= 1'b0;
    end else begin
      err_trig_d_reg     <= err_trig;
      pm_trig_d_reg      <= pm_trig;
      error_insert_pulse <= err_trig && !err_trig_d_reg;
      pm_update_pulse    <= pm_trig && !pm_trig_d_reg;
    end
  end

  // done follows the ports while the request is high, clears when it drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_done_reg <= 1'b0;
    end else if (!pm_trig) begin
      pm_done_reg <= 1'b0;
    end else begin
      pm_done_reg <= ports_done;
    end
  end

  // ==========================================================================
  // pin drivers
  function automatic logic [1:0] pin_drive(input logic [1:0] sel,
                                           input logic       stat);
    logic [1:0] r;
    r = 2'h0;
    if (sel == GCR_PIN_STAT) begin
      r = {1'b1, stat};
    end else if (sel == GCR_PIN_LOW) begin
      r = 2'h2;
    end else if (sel == GCR_PIN_HIGH) begin
      r = 2'h3;
    end
    return r;
  endfunction

  logic [7:0] pin_oe_n;
  logic [7:0] pin_o_n;

  always_comb begin
    logic [1:0] d;
    d        = 2'h0;
    pin_oe_n = 8'h00;
    pin_o_n  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = pin_drive(pin_sel_reg[2*i +: 2], port_status[i]);
      pin_oe_n[i] = d[1];
      pin_o_n[i]  = d[0];
    end
    if (ctrl_two_reg[GCR_C2_REF_O]) begin
      pin_oe_n[1] = 1'b1;
      pin_o_n[1]  = ref8k_internal;
    end
    if (ctrl_two_reg[GCR_C2_REF_I]) begin
      pin_oe_n[3] = 1'b0;
      pin_o_n[3]  = 1'b0;
    end
    if (ctrl_one_reg[GCR_C1_ERR_SRC]) begin
      pin_oe_n[5] = 1'b0;
      pin_o_n[5]  = 1'b0;
    end
    if (pm_mode == GCR_PM_PIN) begin
      pin_oe_n[7] = 1'b0;
      pin_o_n[7]  = 1'b0;
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_out           <= 1'b0;
      irq_pin_oe            <= 1'b0;
      gp_pin_out            <= 8'h00;
      gp_pin_oe             <= 8'h00;
      broadcast_write_mode  <= 1'b0;
      latched_clear_on_read <= 1'b0;
      datapath_reset        <= GCR_C1_RESET[GCR_C1_DP_RST];
      full_reset            <= 1'b0;
      ref8k_source_sel      <= 3'h0;
      ref8k_source_ext      <= 1'b0;
      ref8k_in              <= 1'b0;
      rate_adapter_pin_mode <= 4'h0;
    end else begin
      irq_pin_out <= !irq_act;
      irq_pin_oe  <= irq_act || ctrl_one_reg[GCR_C1_IRQ_IDLE];
      gp_pin_out  <= pin_o_n;
      gp_pin_oe   <= pin_oe_n;
      broadcast_write_mode  <= ctrl_one_reg[GCR_C1_BCAST];
      latched_clear_on_read <= ctrl_one_reg[GCR_C1_CLR_RD];
      datapath_reset        <= ctrl_one_reg[GCR_C1_DP_RST];
      full_reset            <= ctrl_one_reg[GCR_C1_FULL_RST];
      ref8k_source_sel <= ctrl_two_reg[GCR_C2_SRC_HI:GCR_C2_SRC_LO];
      ref8k_source_ext <= ctrl_two_reg[GCR_C2_REF_I];
      ref8k_in <= ctrl_two_reg[GCR_C2_REF_I] && pin_s2_reg[3];
      rate_adapter_pin_mode <= ctrl_two_reg[GCR_C2_CLK_HI:0];
    end
  end

  // ==========================================================================
  // axi read channel
  logic [4:0] rd_idx;
  assign rd_idx = s_axi_araddr[6:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= GCR_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= GCR_RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (s_axi_araddr[7] || s_axi_araddr[1:0] != 2'h0) begin
          s_axi_rresp <= GCR_RESP_SLVERR;
        end else if (rd_idx == GCR_IDX_IDENTITY) begin
          s_axi_rdata <= {16'h0000, GCR_REV_ID, GCR_PART_ID};
        end else if (rd_idx == GCR_IDX_CTRL_ONE) begin
          s_axi_rdata <= {16'h0000, ctrl_one_reg};
        end else if (rd_idx == GCR_IDX_CTRL_TWO) begin
          s_axi_rdata <= {16'h0000, ctrl_two_reg};
        end else if (rd_idx == GCR_IDX_PIN_SEL) begin
          s_axi_rdata <= {16'h0000, pin_sel_reg};
        end else if (rd_idx == GCR_IDX_STATUS) begin
          s_axi_rdata <= {31'h0, pm_done_reg};
        end else begin
          s_axi_rresp <= GCR_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* logic/gcr_pkg.sv */
// package: register map, field layout and reset values of the global control bank
package gcr_pkg;

  // ==========================================================================
  // register offsets (byte addresses on the 32-bit bus = 4 x index)
  localparam logic [4:0] GCR_IDX_IDENTITY = 5'h00;
  localparam logic [4:0] GCR_IDX_CTRL_ONE = 5'h02;
  localparam logic [4:0] GCR_IDX_CTRL_TWO = 5'h04;
  localparam logic [4:0] GCR_IDX_PIN_SEL  = 5'h0A;
  localparam logic [4:0] GCR_IDX_STATUS   = 5'h14;
  localparam int         GCR_ADDR_W       = 8;

  // ==========================================================================
  // control one field positions
  localparam int GCR_C1_BCAST    = 15;
  localparam int GCR_C1_IRQ_IDLE = 14;
  localparam int GCR_C1_ERR_INS  = 7;
  localparam int GCR_C1_ERR_SRC  = 6;
  localparam int GCR_C1_PM_HI    = 5;
  localparam int GCR_C1_PM_LO    = 4;
  localparam int GCR_C1_PM_REQ   = 3;
  localparam int GCR_C1_CLR_RD   = 2;
  localparam int GCR_C1_DP_RST   = 1;
  localparam int GCR_C1_FULL_RST = 0;

  // control two field positions
  localparam int GCR_C2_SRC_HI = 12;
  localparam int GCR_C2_SRC_LO = 10;
  localparam int GCR_C2_REF_O  = 9;
  localparam int GCR_C2_REF_I  = 8;
  localparam int GCR_C2_CLK_HI = 3;

  // ==========================================================================
  // writable masks and reset values
  localparam logic [15:0] GCR_C1_MASK  = 16'hC0FF;
  localparam logic [15:0] GCR_C2_MASK  = 16'h1F0F;
  localparam logic [15:0] GCR_C1_RESET = 16'h0002;
  localparam logic [15:0] GCR_C2_RESET = 16'h0000;
  localparam logic [15:0] GCR_PS_RESET = 16'h0000;

  // identification: arbitrary neutral values
  localparam logic [3:0]  GCR_REV_ID  = 4'h1;
  localparam logic [11:0] GCR_PART_ID = 12'h5A5;

  // pin select encodings
  localparam logic [1:0] GCR_PIN_IN   = 2'h0;
  localparam logic [1:0] GCR_PIN_STAT = 2'h1;
  localparam logic [1:0] GCR_PIN_LOW  = 2'h2;
  localparam logic [1:0] GCR_PIN_HIGH = 2'h3;

  // pm update modes
  localparam logic [1:0] GCR_PM_REG = 2'h0;
  localparam logic [1:0] GCR_PM_PIN = 2'h1;

  // axi responses
  localparam logic [1:0] GCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GCR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [15:0] data;
  } gcr_port_wr_s;

endpackage

/* bench/gcr_monitor.sv */
// checker: bus handshake and output assertions of the global control bank
module gcr_monitor
  import gcr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe,
  input wire logic        error_insert_pulse,
  input wire logic        pm_update_pulse,
  input wire logic        datapath_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus responses
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_err_data_zero: assert property (
    s_axi_rvalid && s_axi_rresp == GCR_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // ==========================================================
  // pins and pulses
  // the first edge after release still shows reset values of the pin
  a_irq_low_drives: assert property (
    $past(aresetn) && !irq_pin_out |-> irq_pin_oe)
    else $error("irq low without drive");
  a_err_pulse_once: assert property (
    error_insert_pulse |=> !error_insert_pulse)
    else $error("error pulse too long");
  a_pm_pulse_once: assert property (
    pm_update_pulse |=> !pm_update_pulse) else $error("pm pulse too long");
  a_dp_rst_default: assert property (
    $rose(aresetn) |-> datapath_reset) else $error("datapath reset low");
endmodule

bind gcr_top gcr_monitor gcr_monitor_inst (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_pin_out, .irq_pin_oe,
  .error_insert_pulse, .pm_update_pulse, .datapath_reset);

/* bench/tb.sv */
// testbench: register access, pin functions and pulses of the control bank
module tb
  import gcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq_active;
  logic        pm_ports_done, one_sec_tick, ref8k_internal, irq_pin_out;
  logic        irq_pin_oe, broadcast_write_mode, error_insert_pulse;
  logic        pm_update_pulse, latched_clear_on_read, datapath_reset;
  logic        full_reset, ref8k_source_ext, ref8k_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, gp_pin_in, port_status;
  logic [7:0]  gp_pin_out, gp_pin_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rate_adapter_pin_mode;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  ref8k_source_sel;
  logic [31:0] rs = 32'hFBB1;
  logic [15:0] v;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          errors, n_compared, cyc, n_err, n_pm, p;
  localparam logic [7:0] A_ID = 8'h00, A_C1 = 8'h08, A_C2 = 8'h10;
  localparam logic [7:0] A_PS = 8'h28, A_ST = 8'h50, A_NO = 8'h0C;
  localparam logic [1:0] OK = GCR_RESP_OKAY;

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  gcr_top gcr_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_active, .pm_ports_done, .one_sec_tick, .gp_pin_in,
    .port_status, .ref8k_internal, .irq_pin_out, .irq_pin_oe, .gp_pin_out,
    .gp_pin_oe, .broadcast_write_mode, .error_insert_pulse,
    .pm_update_pulse, .latched_clear_on_read, .datapath_reset, .full_reset,
    .ref8k_source_sel, .ref8k_source_ext, .ref8k_in, .rate_adapter_pin_mode
  );

  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // expected {oe, driven out} of the eight pins with no overrides active
  function logic [15:0] pins(input logic [15:0] ps, input logic [7:0] st);
    logic [1:0] c;
    pins = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      c = ps[2*i +: 2];
      pins[8+i] = (c != GCR_PIN_IN);
      pins[i] = (c == GCR_PIN_HIGH) || (c == GCR_PIN_STAT && st[i]);
    end
  endfunction

  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task wt();
    repeat (8) @(posedge aclk);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // response watcher, pulse counters and hang limit
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (error_insert_pulse === 1'b1) n_err++;
    if (pm_update_pulse === 1'b1) n_pm++;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, irq_active, pm_ports_done} = 4'h0;
    {one_sec_tick, ref8k_internal} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, gp_pin_in, port_status} = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_ID, {18'h0, GCR_REV_ID, GCR_PART_ID});
    rd(A_C1, {18'h0, GCR_C1_RESET});
    rd(A_C2, 34'h0);
    rd(A_PS, 34'h0);
    chk("dp_reset", 34'h1, 34'(datapath_reset));
    $display("test reset values done");
    gp_pin_in <= 8'h08;
    wr(A_C1, 16'hFFF8, OK);
    rd(A_C1, {18'h0, 16'hFFF8 & GCR_C1_MASK});
    wr(A_C2, 16'hFFFF, OK);
    rd(A_C2, {18'h0, GCR_C2_MASK});
    wt();
    chk("bcast", 34'h1, 34'(broadcast_write_mode));
    chk("src_sel", 34'h7, 34'(ref8k_source_sel));
    chk("clk_mode", 34'hF, 34'(rate_adapter_pin_mode));
    chk("ref_in", 34'h1, 34'(ref8k_in));
    chk("src_ext", 34'h1, 34'(ref8k_source_ext));
    wr(A_C1, 16'h0007, OK);
    wr(A_C2, 16'h0000, OK);
    wt();
    chk("resets", 34'h7,
        34'({latched_clear_on_read, datapath_reset, full_reset}));
    chk("ref_off", 34'h0, 34'(ref8k_in));
    chk("ext_off", 34'h0, 34'(ref8k_source_ext));
    wr(A_C1, 16'h0000, OK);
    $display("test control fields done");
    for (int k = 0; k < 8; k++) begin
      v = (k < 4) ? {8{2'(k)}} : 16'(rnd());
      port_status <= 8'(rnd());
      wr(A_PS, v, OK);
      rd(A_PS, {18'h0, v});
      wt();
      chk("pins", 34'(pins(v, port_status)),
          34'({gp_pin_oe, gp_pin_out & gp_pin_oe}));
    end
    // only the upper byte lane is enabled, the lower byte must survive
    s_axi_wstrb <= 4'h2;
    wr(A_PS, 16'hFFFF, OK);
    rd(A_PS, {18'h0, 8'hFF, v[7:0]});
    s_axi_wstrb <= 4'hF;
    wr(A_C1, 16'h0050, OK);
    wr(A_C2, 16'h0300, OK);
    wr(A_PS, 16'hFFFF, OK);
    gp_pin_in <= 8'h00;
    wt();
    chk("override", 34'h5755,
        34'({gp_pin_oe, gp_pin_out & gp_pin_oe}));
    ref8k_internal <= 1'b1;
    wt();
    chk("ref_out", 34'h5757, 34'({gp_pin_oe, gp_pin_out & gp_pin_oe}));
    $display("test pin functions done");
    gp_pin_in <= 8'h20;
    wt();
    chk("pin_trig", 34'h1, 34'(n_err));
    wr(A_C1, 16'h00D0, OK);
    wt();
    chk("masked", 34'h1, 34'(n_err));
    wr(A_C1, 16'h0000, OK);
    wr(A_C1, 16'h0080, OK);
    wt();
    chk("reg_trig", 34'h2, 34'(n_err));
    wr(A_C1, 16'h0000, OK);
    p = n_pm;
    pm_ports_done <= 1'b1;
    wr(A_C1, 16'h0008, OK);
    wt();
    chk("pm_reg", 34'(p + 1), 34'(n_pm));
    rd(A_ST, 34'h1);
    wr(A_C1, 16'h0000, OK);
    wt();
    rd(A_ST, 34'h0);
    wr(A_C1, 16'h0010, OK);
    gp_pin_in <= 8'hA0;
    wt();
    chk("pm_pin", 34'(p + 2), 34'(n_pm));
    wr(A_C1, 16'h0020, OK);
    one_sec_tick <= 1'b1;
    wt();
    one_sec_tick <= 1'b0;
    wr(A_C1, 16'h0028, OK);
    wt();
    chk("pm_tick", 34'(p + 3), 34'(n_pm));
    $display("test pulses done");
    rd(A_NO, {GCR_RESP_SLVERR, 32'h0});
    wr(A_NO, 16'hFFFF, GCR_RESP_SLVERR);
    wr(A_ID, 16'h0000, OK);
    rd(A_ID, {18'h0, GCR_REV_ID, GCR_PART_ID});
    $display("test refusals done");
    wr(A_C1, 16'h0000, OK);
    irq_active <= 1'b1;
    wt();
    chk("irq_act", 34'h2, {irq_pin_oe, irq_pin_out});
    irq_active <= 1'b0;
    wt();
    chk("irq_float", 34'h0, 34'(irq_pin_oe));
    wr(A_C1, 16'h4000, OK);
    wt();
    chk("irq_high", 34'h3, {irq_pin_oe, irq_pin_out});
    $display("test irq pin done");
    stop_test();
  end
endmodule
